// ==== verilog/vrd_pkg.sv ====
package vrd_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_REF8_CONTROL0 = 8'h00;
    localparam logic [7:0] OFS_REF8_LEVEL = 8'h04;
    localparam logic [7:0] OFS_REF5_CONTROL0 = 8'h08;
    localparam logic [7:0] OFS_REF5_LEVEL = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    // Writable bit masks, unimplemented bits clear
    localparam logic [7:0] MASK_REF8_CONTROL0 = 8'hBD;
    localparam logic [7:0] MASK_REF8_LEVEL = 8'hFF;
    localparam logic [7:0] MASK_REF5_CONTROL0 = 8'hED;
    localparam logic [7:0] MASK_REF5_LEVEL = 8'h1F;
    // Reset values
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_LEVEL = 8'h00;
    // Shared control field positions
    localparam int BIT_ENABLE = 7;
    localparam int BIT_LP_SOURCE = 6;
    localparam int BIT_OUT1 = 5;
    localparam int BIT_OUT2 = 4;
    localparam int BIT_PSS_HI = 3;
    localparam int BIT_PSS_LO = 2;
    localparam int BIT_NSS = 0;
    localparam int REF5_CODE_W = 5;
    // Positive source codes
    localparam logic [1:0] PSS_SUPPLY = 2'h0;
    localparam logic [1:0] PSS_REF_PIN = 2'h1;
    localparam logic [1:0] PSS_FIXED = 2'h2;
    localparam logic [1:0] PSS_RESERVED = 2'h3;
    // Low-power clamp codes
    localparam logic [4:0] CODE_CLAMP_POS = 5'h1F;
    localparam logic [4:0] CODE_CLAMP_NEG = 5'h00;
    // Status bit positions
    localparam int ST_REF8_ON = 0;
    localparam int ST_REF5_ON = 1;
    localparam int ST_CLAMP_POS = 2;
    localparam int ST_CLAMP_NEG = 3;
    localparam int ST_SLEEP = 4;
endpackage : vrd_pkg

// ==== verilog/vrd_top.sv ====
`timescale 1ns/1ps
module vrd_top
    import vrd_pkg::*;
#(
    parameter int REF8_CODE_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Power state
    input wire logic sleep_mode,
    // 8-bit ladder switches
    output logic ref8_ladder_on,
    output logic [2:0] ref8_pos_switch,
    output logic ref8_neg_to_pin,
    output logic [REF8_CODE_W-1:0] ref8_tap,
    // 8-bit pin routing
    output logic ref8_pin1_connect,
    output logic ref8_pin2_connect,
    input wire logic ref8_pin1_in,
    input wire logic ref8_pin2_in,
    output logic ref8_pin1_rd,
    output logic ref8_pin2_rd,
    // 5-bit ladder switches
    output logic ref5_ladder_on,
    output logic [2:0] ref5_pos_switch,
    output logic ref5_neg_to_pin,
    output logic ref5_pos_connect,
    output logic ref5_neg_connect,
    output logic [REF5_CODE_W-1:0] ref5_tap,
    output logic ref5_clamp_pos,
    output logic ref5_clamp_neg,
    // 5-bit pin routing
    output logic ref5_pin_connect,
    input wire logic ref5_pin_in,
    output logic ref5_pin_rd
);

////////////////////////////////////////////////////////////////////////////////
// Registers
logic [7:0] ref8_control0_q;
logic [7:0] ref8_control0_d;
logic [7:0] ref8_level_q;
logic [7:0] ref8_level_d;
logic [7:0] ref5_control0_q;
logic [7:0] ref5_control0_d;
logic [7:0] ref5_level_q;
logic [7:0] ref5_level_d;
logic [31:0] prdata_q;
logic [31:0] prdata_d;

////////////////////////////////////////////////////////////////////////////////
// APB decode
wire setup_ph = psel & ~penable;
wire access_ph = psel & penable;
wire wr_lane0 = access_ph & pwrite & pstrb[0];
wire hit_r8c0 = (paddr == OFS_REF8_CONTROL0);
wire hit_r8lv = (paddr == OFS_REF8_LEVEL);
wire hit_r5c0 = (paddr == OFS_REF5_CONTROL0);
wire hit_r5lv = (paddr == OFS_REF5_LEVEL);
wire hit_stat = (paddr == OFS_STATUS);
wire hit_any = hit_r8c0 | hit_r8lv | hit_r5c0 | hit_r5lv | hit_stat;
wire wr_r8c0 = wr_lane0 & hit_r8c0;
wire wr_r8lv = wr_lane0 & hit_r8lv;
wire wr_r5c0 = wr_lane0 & hit_r5c0;
wire wr_r5lv = wr_lane0 & hit_r5lv;

// Zero wait states; error on unmapped address or status write
assign pready = 1'b1;
assign pslverr = access_ph & (~hit_any | (pwrite & hit_stat));
assign prdata = prdata_q;

////////////////////////////////////////////////////////////////////////////////
// Register next values
// Unimplemented bits masked off on write
assign ref8_control0_d = wr_r8c0 ? (pwdata[7:0] & MASK_REF8_CONTROL0)
                                 : ref8_control0_q;
assign ref8_level_d = wr_r8lv ? (pwdata[7:0] & MASK_REF8_LEVEL)
                              : ref8_level_q;
assign ref5_control0_d = wr_r5c0 ? (pwdata[7:0] & MASK_REF5_CONTROL0)
                                 : ref5_control0_q;
assign ref5_level_d = wr_r5lv ? (pwdata[7:0] & MASK_REF5_LEVEL)
                              : ref5_level_q;

// Control registers; sleep and wake never touch them
always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
        ref8_control0_q <= RST_CONTROL;
        ref8_level_q <= RST_LEVEL;
        ref5_control0_q <= RST_CONTROL;
        ref5_level_q <= RST_LEVEL;
    end else begin
        ref8_control0_q <= ref8_control0_d;
        ref8_level_q <= ref8_level_d;
        ref5_control0_q <= ref5_control0_d;
        ref5_level_q <= ref5_level_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Field views
wire r8_en = ref8_control0_q[BIT_ENABLE];
wire r8_oe1 = ref8_control0_q[BIT_OUT1];
wire r8_oe2 = ref8_control0_q[BIT_OUT2];
wire [1:0] r8_pss = ref8_control0_q[BIT_PSS_HI:BIT_PSS_LO];
wire r8_nss = ref8_control0_q[BIT_NSS];
wire r5_en = ref5_control0_q[BIT_ENABLE];
wire r5_lps = ref5_control0_q[BIT_LP_SOURCE];
wire r5_oe = ref5_control0_q[BIT_OUT1];
wire [1:0] r5_pss = ref5_control0_q[BIT_PSS_HI:BIT_PSS_LO];
wire r5_nss = ref5_control0_q[BIT_NSS];
wire [REF5_CODE_W-1:0] r5_code = ref5_level_q[REF5_CODE_W-1:0];

// Positive source one-hot: supply, ref pin, fixed_reference
function automatic logic [2:0] pos_onehot(input logic [1:0] sel);
    logic [2:0] oh;
    oh = 3'h0;
    unique case (sel)
        PSS_SUPPLY: oh = 3'h1;
        PSS_REF_PIN: oh = 3'h2;
        PSS_FIXED: oh = 3'h4;
        PSS_RESERVED: oh = 3'h0;
    endcase
    return oh;
endfunction : pos_onehot

////////////////////////////////////////////////////////////////////////////////
// Decoded switch controls for the ladders
wire r5_clamp_pos_d = ~r5_en & r5_lps & (r5_code == CODE_CLAMP_POS);
wire r5_clamp_neg_d = ~r5_en & ~r5_lps & (r5_code == CODE_CLAMP_NEG);
wire r5_live = r5_en | r5_clamp_pos_d | r5_clamp_neg_d;
wire [2:0] r8_pos_d = r8_en ? pos_onehot(r8_pss) : 3'h0;
wire [2:0] r5_pos_d = r5_live ? pos_onehot(r5_pss) : 3'h0;
// Source disconnect while in low-power state
wire r5_pos_con_d = r5_en | r5_lps;
wire r5_neg_con_d = r5_en | ~r5_lps;
wire [REF5_CODE_W-1:0] r5_tap_d = r5_live ? r5_code : CODE_CLAMP_NEG;
wire [REF8_CODE_W-1:0] r8_tap_d = r8_en ? ref8_level_q[REF8_CODE_W-1:0]
                                        : {REF8_CODE_W{1'b0}};
wire r8_pin1_d = r8_oe1;
wire r8_pin2_d = r8_oe2;
wire r5_pin_d = r5_oe;

// Switch outputs, one edge after the register update
always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
        ref8_ladder_on <= 1'b0;
        ref8_pos_switch <= 3'h0;
        ref8_neg_to_pin <= 1'b0;
        ref8_tap <= '0;
        ref8_pin1_connect <= 1'b0;
        ref8_pin2_connect <= 1'b0;
    end else begin
        ref8_ladder_on <= r8_en;
        ref8_pos_switch <= r8_pos_d;
        ref8_neg_to_pin <= r8_en & r8_nss;
        ref8_tap <= r8_tap_d;
        ref8_pin1_connect <= r8_pin1_d;
        ref8_pin2_connect <= r8_pin2_d;
    end
end

// 5-bit converter switch outputs
always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
        ref5_ladder_on <= 1'b0;
        ref5_pos_switch <= 3'h0;
        ref5_neg_to_pin <= 1'b0;
        ref5_pos_connect <= 1'b0;
        ref5_neg_connect <= 1'b0;
        ref5_tap <= '0;
        ref5_clamp_pos <= 1'b0;
        ref5_clamp_neg <= 1'b0;
        ref5_pin_connect <= 1'b0;
    end else begin
        ref5_ladder_on <= r5_en;
        ref5_pos_switch <= r5_pos_d;
        ref5_neg_to_pin <= r5_live & r5_nss;
        ref5_pos_connect <= r5_pos_con_d;
        ref5_neg_connect <= r5_neg_con_d;
        ref5_tap <= r5_tap_d;
        ref5_clamp_pos <= r5_clamp_pos_d;
        ref5_clamp_neg <= r5_clamp_neg_d;
        ref5_pin_connect <= r5_pin_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Pin read path; routed pins read as zero
always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
        ref8_pin1_rd <= 1'b0;
        ref8_pin2_rd <= 1'b0;
        ref5_pin_rd <= 1'b0;
    end else begin
        ref8_pin1_rd <= ref8_pin1_in & ~ref8_pin1_connect;
        ref8_pin2_rd <= ref8_pin2_in & ~ref8_pin2_connect;
        ref5_pin_rd <= ref5_pin_in & ~ref5_pin_connect;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read data, captured in the setup cycle
logic [7:0] status_v;
assign status_v = {3'h0, sleep_mode, ref5_clamp_neg, ref5_clamp_pos,
                   ref5_ladder_on, ref8_ladder_on};

// Read mux
always_comb begin
    prdata_d = prdata_q;
    if (setup_ph && !pwrite) begin
        prdata_d = 32'h0;
        if (hit_r8c0) begin
            prdata_d[7:0] = ref8_control0_q & MASK_REF8_CONTROL0;
        end
        if (hit_r8lv) begin
            prdata_d[7:0] = ref8_level_q;
        end
        if (hit_r5c0) begin
            prdata_d[7:0] = ref5_control0_q;
        end
        if (hit_r5lv) begin
            prdata_d[7:0] = ref5_level_q & MASK_REF5_LEVEL;
        end
        if (hit_stat) begin
            prdata_d[7:0] = status_v;
        end
    end
end

// Read data register
always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
        prdata_q <= 32'h0;
    end else begin
        prdata_q <= prdata_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Assertions
default clocking cb @(posedge clk); endclocking
default disable iff (rst);

AST_R8_ENABLE_FOLLOWS: assert property (
    $past(ref8_control0_q[BIT_ENABLE]) == ref8_ladder_on)
    else $error("8-bit ladder enable does not follow control bit");

AST_R8_PINS_FOLLOW: assert property (
    wr_r8c0 ##1 1'b1 |=> ref8_pin1_connect == $past(pwdata[BIT_OUT1], 2)
        && ref8_pin2_connect == $past(pwdata[BIT_OUT2], 2))
    else $error("8-bit pin routing does not follow written bits");

AST_R8_POS_SOURCE: assert property (
    $past(r8_en && r8_pss == PSS_FIXED) |-> ref8_pos_switch == 3'h4)
    else $error("8-bit positive source not fixed_reference for code 10");

AST_R8_NEG_SOURCE: assert property (
    ref8_ladder_on && !$past(r8_nss) |-> !ref8_neg_to_pin)
    else $error("8-bit negative end left on pin while ground chosen");

AST_R8_LEVEL_TAP: assert property (
    wr_r8lv && r8_en ##1 r8_en |=> ref8_tap == $past(pwdata[7:0], 2))
    else $error("8-bit tap does not match written level");

AST_R8_UNIMPL_ZERO: assert property (
    ref8_control0_q[6] == 1'b0 && ref8_control0_q[1] == 1'b0)
    else $error("unimplemented control bits became set");

AST_SLEEP_HOLDS: assert property (
    !wr_r8c0 && !wr_r5c0 |=> $stable(ref8_control0_q) && $stable(ref5_control0_q))
    else $error("control register changed without a write");

AST_RESET_CLEARS: assert property (
    $fell(rst) |-> ref8_control0_q == RST_CONTROL && ref8_level_q == RST_LEVEL
        && !ref8_pin1_connect && !ref8_ladder_on)
    else $error("reset did not clear converter state");

AST_R5_TAP: assert property (
    $past(r5_en) |-> ref5_tap == $past(r5_code))
    else $error("5-bit tap differs from level code while enabled");

AST_PIN_READ_ZERO: assert property (
    ref8_pin1_connect ##1 ref8_pin1_connect |-> !ref8_pin1_rd)
    else $error("routed pin read returned one");

AST_CLAMP_POS: assert property (
    !r5_en && r5_lps && r5_code == CODE_CLAMP_POS |=> ref5_clamp_pos
        && ref5_pos_connect && !ref5_neg_connect)
    else $error("positive clamp not applied");

AST_CLAMP_NEG: assert property (
    !r5_en && !r5_lps && r5_code == CODE_CLAMP_NEG |=> ref5_clamp_neg
        && !ref5_pos_connect && ref5_neg_connect)
    else $error("negative clamp not applied");

AST_R5_LEVEL_MASK: assert property (
    ref5_level_q[7:5] == 3'h0)
    else $error("5-bit level upper bits set");

AST_APB_NO_WAIT: assert property (
    access_ph |-> pready)
    else $error("slave inserted a wait state");

// Main scenarios
COV_R8_ROUTED: cover property (ref8_ladder_on && ref8_pin1_connect && ref8_pin2_connect);
COV_CLAMP_POS: cover property (ref5_clamp_pos && sleep_mode);
COV_CLAMP_NEG: cover property (ref5_clamp_neg);
COV_UNMAPPED: cover property (pslverr);

endmodule : vrd_top

// ==== dv/vrd_pin_model.sv ====
`timescale 1ns/1ps
module vrd_pin_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Level driven onto the pins from outside
    input wire logic ext_level,
    // Converter routing from the block
    input wire logic connect1,
    input wire logic connect2,
    input wire logic connect5,
    // Digital levels seen by the pin detectors
    output logic pin1_in,
    output logic pin2_in,
    output logic pin5_in
);
    logic toggle_q;
    ////////////////////////////////////////////////////////////////////////////////
    // Analogue pin holds no digital level, so show a changing pattern
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            toggle_q <= 1'b0;
        end else begin
            toggle_q <= ~toggle_q;
        end
    end
    // Routed pins carry the toggling pattern, others the outside level
    assign pin1_in = connect1 ? toggle_q : ext_level;
    assign pin2_in = connect2 ? toggle_q : ext_level;
    assign pin5_in = connect5 ? toggle_q : ext_level;
endmodule : vrd_pin_model

// ==== dv/tb.sv ====
`timescale 1ns/1ps
module tb;
    import vrd_pkg::*;
    // Bus and control stimulus
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic sleep_mode = 1'b0;
    logic ext_level = 1'b1;
    // Design outputs
    logic [31:0] prdata;
    logic pready, pslverr, r8_on, r8_neg, c1, c2, p1_in, p2_in, p1_rd, p2_rd;
    logic [2:0] r8_pos, r5_pos;
    logic [7:0] r8_tap;
    logic r5_on, r5_neg, r5_pc, r5_nc, r5_cp, r5_cn, c5, p5_in, p5_rd;
    logic [4:0] r5_tap;
    logic [31:0] rd_v;
    logic err_v;
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // Design and pin model
    vrd_top uut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_mode(sleep_mode), .ref8_ladder_on(r8_on),
        .ref8_pos_switch(r8_pos), .ref8_neg_to_pin(r8_neg), .ref8_tap(r8_tap),
        .ref8_pin1_connect(c1), .ref8_pin2_connect(c2), .ref8_pin1_in(p1_in),
        .ref8_pin2_in(p2_in), .ref8_pin1_rd(p1_rd), .ref8_pin2_rd(p2_rd),
        .ref5_ladder_on(r5_on), .ref5_pos_switch(r5_pos), .ref5_neg_to_pin(r5_neg),
        .ref5_pos_connect(r5_pc), .ref5_neg_connect(r5_nc), .ref5_tap(r5_tap),
        .ref5_clamp_pos(r5_cp), .ref5_clamp_neg(r5_cn), .ref5_pin_connect(c5),
        .ref5_pin_in(p5_in), .ref5_pin_rd(p5_rd));
    vrd_pin_model pins (.clk(clk), .rst(rst), .ext_level(ext_level), .connect1(c1),
        .connect2(c2), .connect5(c5), .pin1_in(p1_in), .pin2_in(p2_in), .pin5_in(p5_in));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            failures++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Compare and report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            end_sim();
        end
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        chk(rd_v, exp);
        chk({31'h0, err_v}, {31'h0, e});
    endtask : rd
    // Let decoded and pin-read outputs land
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) rd(8'(4 * i), 32'h0, 1'b0);
        settle();
        chk({r8_on, r5_on, c1, c2, c5, r8_tap}, 13'h0);
        chk({p1_rd, p2_rd, p5_rd}, 3'h7);
        wr(OFS_REF8_CONTROL0, 8'hF7);
        rd(OFS_REF8_CONTROL0, 32'hB5, 1'b0);
        settle();
        chk({r8_on, c1, c2, r8_neg, r8_pos}, 7'h7A);
        chk({p1_rd, p2_rd}, 2'h0);
        for (int k = 0; k < 3; k++) begin
            wr(OFS_REF8_CONTROL0, 8'(8'h80 | (k << 2)));
            settle();
            chk({c1, c2, r8_neg, r8_pos}, {3'h0, 3'(1 << k)});
            chk({p1_rd, p2_rd}, 2'h3);
        end
        wr(OFS_REF8_LEVEL, 8'hA5);
        rd(OFS_REF8_LEVEL, 32'hA5, 1'b0);
        settle();
        chk(r8_tap, 8'hA5);
        pstrb <= 4'hE;
        wr(OFS_REF8_LEVEL, 8'h3C);
        pstrb <= 4'hF;
        rd(OFS_REF8_LEVEL, 32'hA5, 1'b0);
        wr(OFS_REF5_LEVEL, 8'hFF);
        rd(OFS_REF5_LEVEL, 32'h1F, 1'b0);
        wr(OFS_REF5_LEVEL, 8'h13);
        wr(OFS_REF5_CONTROL0, 8'hA5);
        settle();
        chk({r5_on, r5_pc, r5_nc, r5_tap, r5_pos, r5_neg}, 12'hF35);
        chk({c5, p5_rd}, 2'h2);
        wr(OFS_REF5_LEVEL, 8'h1F);
        wr(OFS_REF5_CONTROL0, 8'h48);
        settle();
        chk({r5_on, r5_cp, r5_cn, r5_pc, r5_nc, r5_tap}, 10'h15F);
        chk({r5_pos, c5, p5_rd}, 5'h11);
        wr(OFS_REF5_LEVEL, 8'h00);
        wr(OFS_REF5_CONTROL0, 8'h01);
        settle();
        chk({r5_on, r5_cp, r5_cn, r5_pc, r5_nc, r5_neg}, 6'h0B);
        @(posedge clk);
        sleep_mode <= 1'b1;
        rd(OFS_STATUS, 32'h19, 1'b0);
        settle();
        chk({r8_on, r8_pos, r8_tap, r5_cn}, 13'h194B);
        @(posedge clk);
        sleep_mode <= 1'b0;
        rd(OFS_REF8_CONTROL0, 32'h88, 1'b0);
        rd(OFS_REF5_CONTROL0, 32'h01, 1'b0);
        rd(8'h20, 32'h0, 1'b1);
        apb(1'b1, OFS_STATUS, 32'hFF);
        chk({31'h0, err_v}, 32'h1);
        rd(OFS_STATUS, 32'h09, 1'b0);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk({r8_on, r5_on, r5_cn, c1, c2, c5, r8_tap, r5_tap}, 19'h0);
        @(posedge clk);
        rst <= 1'b0;
        rd(OFS_REF8_CONTROL0, 32'h0, 1'b0);
        rd(OFS_REF8_LEVEL, 32'h0, 1'b0);
        end_sim();
    end
endmodule : tb
